// [logic/fzo_regs.svh]
// register offsets, reset values and fixed codes of the fan zone limit block
// assumes it is included by bare name from the files that need it
`ifndef FZO_REGS_SVH
`define FZO_REGS_SVH

// ==========================================================
// register offsets on the management register port
`define FZO_OFS_LOW1      8'h67
`define FZO_OFS_LOW2      8'h68
`define FZO_OFS_LOW3      8'h69
`define FZO_OFS_ABS1      8'h6a
`define FZO_OFS_ABS2      8'h6b
`define FZO_OFS_ABS3      8'h6c
`define FZO_OFS_XOR       8'h6f

// ==========================================================
// reset values
`define FZO_RST_LOW       8'h80
`define FZO_RST_ABS       8'h64
`define FZO_RST_XOR       8'h00

// ==========================================================
// field positions and special codes
`define FZO_XEN_BIT       0
`define FZO_LOW_INVALID   8'h80
`define FZO_ABS_DISABLE   8'h80
`define FZO_DUTY_FULL     8'hff
`define FZO_DUTY_OFF      8'h00
`define FZO_DUTY_KICK     8'h01
`define FZO_READ_NONE     8'h00

// ==========================================================
// span in whole degrees from low limit to full duty, per range code
// fractional spans are rounded up to the next whole degree
`define FZO_SPAN_0        9'h002
`define FZO_SPAN_1        9'h003
`define FZO_SPAN_2        9'h004
`define FZO_SPAN_3        9'h004
`define FZO_SPAN_4        9'h005
`define FZO_SPAN_5        9'h007
`define FZO_SPAN_6        9'h008
`define FZO_SPAN_7        9'h00a
`define FZO_SPAN_8        9'h00e
`define FZO_SPAN_9        9'h010
`define FZO_SPAN_A        9'h014
`define FZO_SPAN_B        9'h01b
`define FZO_SPAN_C        9'h020
`define FZO_SPAN_D        9'h028
`define FZO_SPAN_E        9'h036
`define FZO_SPAN_F        9'h050

`endif

// [logic/fzo_pkg.sv]
// types shared by the fan zone limit block
// assumes nothing beyond a SystemVerilog compiler
package fzo_pkg;

   // ==========================================================
   // channel control mode, supplied by the channel configuration
   typedef enum logic [1:0] {
      FZO_MODE_MANUAL   = 2'b00,   // duty from manual setting
      FZO_MODE_AUTO     = 2'b01,   // duty from zone ramp
      FZO_MODE_DISABLED = 2'b10    // output held off, never overridden
   } fzo_mode_t;

   // signed celsius reading or limit
   typedef logic signed [7:0] fzo_temp_t;

endpackage : fzo_pkg

// [logic/fzo_zone_ramp.sv]
// one channel's automatic duty computation from a zone reading
// assumes temperature and limit are signed two's-complement celsius
`timescale 1ns/1ps
`include "fzo_regs.svh"

module fzo_zone_ramp
   import fzo_pkg::*;
(
   input  wire fzo_temp_t   temp,            // measured zone temperature
   input  wire fzo_temp_t   low_limit,       // zone low limit
   input  wire logic [7:0]  min_duty,        // channel minimum duty
   input  wire logic [3:0]  zone_range_code, // slope select
   output logic      [7:0]  auto_duty        // computed duty
);

   // ==========================================================
   // range code to degrees of span
   function automatic logic [8:0] span_of(input logic [3:0] code);
      logic [8:0] s;
      s = `FZO_SPAN_F;
      unique case (code)
         4'h0: s = `FZO_SPAN_0;
         4'h1: s = `FZO_SPAN_1;
         4'h2: s = `FZO_SPAN_2;
         4'h3: s = `FZO_SPAN_3;
         4'h4: s = `FZO_SPAN_4;
         4'h5: s = `FZO_SPAN_5;
         4'h6: s = `FZO_SPAN_6;
         4'h7: s = `FZO_SPAN_7;
         4'h8: s = `FZO_SPAN_8;
         4'h9: s = `FZO_SPAN_9;
         4'ha: s = `FZO_SPAN_A;
         4'hb: s = `FZO_SPAN_B;
         4'hc: s = `FZO_SPAN_C;
         4'hd: s = `FZO_SPAN_D;
         4'he: s = `FZO_SPAN_E;
         4'hf: s = `FZO_SPAN_F;
      endcase
      return s;
   endfunction : span_of

   logic signed [8:0] delta;    // temperature above limit, widened
   logic        [8:0] span;     // degrees to reach full duty
   logic        [16:0] scaled;  // headroom times delta

   // ==========================================================
   // ramp: min duty at the limit, full duty once span is reached
   always_comb begin
      delta  = 9'(temp) - 9'(low_limit);
      span   = span_of(zone_range_code);
      scaled = 17'(`FZO_DUTY_FULL - min_duty) * 17'(delta[7:0]);
      if (delta < 0) begin
         auto_duty = min_duty;                    // below limit holds minimum
      end else if (delta == 0) begin
         // at the limit a zero minimum still turns the fan on
         auto_duty = (min_duty == `FZO_DUTY_OFF) ? `FZO_DUTY_KICK : min_duty;
      end else if (delta >= span) begin
         auto_duty = `FZO_DUTY_FULL;
      end else begin
         // quotient never exceeds headroom since delta is below span
         auto_duty = min_duty + 8'(scaled / 17'(span));
      end
   end

endmodule : fzo_zone_ramp

// [logic/fzo_limit_core.sv]
// zone limit registers, full-speed override and xor board test tree
// assumes a byte register port decoded from the management serial bus,
// and channel config, readings and minimum duty supplied by sibling blocks
`timescale 1ns/1ps
`include "fzo_regs.svh"

module fzo_limit_core
   import fzo_pkg::*;
(
   input  wire logic        clk,               // system clock, 100 MHz
   input  wire logic        rst_n,             // synchronous reset, active low
   // register port
   input  wire logic [7:0]  reg_addr,          // register offset
   input  wire logic        reg_wr,            // write strobe, one cycle
   input  wire logic [7:0]  reg_wdata,         // write data
   output logic      [7:0]  reg_rdata,         // read data for reg_addr, registered
   input  wire logic        config_lock,       // lock bit level
   // zone readings
   input  wire logic [7:0]  zone_temp_1,       // signed celsius
   input  wire logic [7:0]  zone_temp_2,
   input  wire logic [7:0]  zone_temp_3,
   // per-channel configuration from sibling registers
   input  wire fzo_mode_t   chan_mode_1,
   input  wire fzo_mode_t   chan_mode_2,
   input  wire fzo_mode_t   chan_mode_3,
   input  wire logic [1:0]  chan_zone_1,       // zone select 0..2
   input  wire logic [1:0]  chan_zone_2,
   input  wire logic [1:0]  chan_zone_3,
   input  wire logic [7:0]  min_duty_1,
   input  wire logic [7:0]  min_duty_2,
   input  wire logic [7:0]  min_duty_3,
   input  wire logic [3:0]  zone_range_code_1, // slope of each zone
   input  wire logic [3:0]  zone_range_code_2,
   input  wire logic [3:0]  zone_range_code_3,
   input  wire logic [7:0]  manual_duty_1,
   input  wire logic [7:0]  manual_duty_2,
   input  wire logic [7:0]  manual_duty_3,
   // duty results to the pwm generators
   output logic      [7:0]  duty_1,            // registered
   output logic      [7:0]  duty_2,
   output logic      [7:0]  duty_3,
   output logic             full_speed,        // override active, registered
   // test pins
   input  wire logic [3:0]  speed_sense_in,    // four tach inputs
   input  wire logic        fan_drive_in_2,    // pad level of drive pin 2
   input  wire logic        fan_drive_in_3,    // pad level of drive pin 3
   output logic             fan_drive_oe_n_2,  // low while driving pin 2
   output logic             fan_drive_oe_n_3,  // low while driving pin 3
   output logic             xor_test_out       // tree result, registered
);

   // ==========================================================
   // register state
   fzo_temp_t   low_q   [3];   // zone low limits
   fzo_temp_t   low_d   [3];
   fzo_temp_t   abs_q   [3];   // zone absolute limits
   fzo_temp_t   abs_d   [3];
   logic        xen_q;         // xor tree enable
   logic        xen_d;
   logic [7:0]  rdata_q;       // read data pipeline
   logic [7:0]  rdata_d;

   // ==========================================================
   // register write and read decode, next values
   always_comb begin
      low_d   = low_q;
      abs_d   = abs_q;
      xen_d   = xen_q;
      rdata_d = `FZO_READ_NONE;
      // writes under lock are dropped with no error indication
      if (reg_wr && !config_lock) begin
         unique case (reg_addr)
            `FZO_OFS_LOW1: low_d[0] = reg_wdata;
            `FZO_OFS_LOW2: low_d[1] = reg_wdata;
            `FZO_OFS_LOW3: low_d[2] = reg_wdata;
            `FZO_OFS_ABS1: abs_d[0] = reg_wdata;
            `FZO_OFS_ABS2: abs_d[1] = reg_wdata;
            `FZO_OFS_ABS3: abs_d[2] = reg_wdata;
            `FZO_OFS_XOR:  xen_d    = reg_wdata[`FZO_XEN_BIT];
            default:       ;   // other offsets belong to sibling blocks
         endcase
      end
      unique case (reg_addr)
         `FZO_OFS_LOW1: rdata_d = low_q[0];
         `FZO_OFS_LOW2: rdata_d = low_q[1];
         `FZO_OFS_LOW3: rdata_d = low_q[2];
         `FZO_OFS_ABS1: rdata_d = abs_q[0];
         `FZO_OFS_ABS2: rdata_d = abs_q[1];
         `FZO_OFS_ABS3: rdata_d = abs_q[2];
         // reserved bits of the test register read as zero
         `FZO_OFS_XOR:  rdata_d = {7'h00, xen_q};
         default:       rdata_d = `FZO_READ_NONE;
      endcase
   end

   // register update
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         low_q   <= '{default: `FZO_RST_LOW};
         abs_q   <= '{default: `FZO_RST_ABS};
         xen_q   <= 1'b0;
         rdata_q <= `FZO_READ_NONE;
      end else begin
         low_q   <= low_d;
         abs_q   <= abs_d;
         xen_q   <= xen_d;
         rdata_q <= rdata_d;
      end
   end

   assign reg_rdata = rdata_q;

   // ==========================================================
   // zone selection helper, illegal select falls back to zone 1
   function automatic logic [1:0] zone_idx(input logic [1:0] sel);
      return (sel > 2'h2) ? 2'h0 : sel;
   endfunction : zone_idx

   fzo_temp_t   temp   [3];    // readings as signed values
   fzo_mode_t   mode   [3];
   logic [1:0]  zsel   [3];
   logic [7:0]  mind   [3];
   logic [3:0]  rng    [3];
   logic [7:0]  mand   [3];
   logic [7:0]  ramp   [3];    // ramp results per channel

   always_comb begin
      temp = '{zone_temp_1, zone_temp_2, zone_temp_3};
      mode = '{chan_mode_1, chan_mode_2, chan_mode_3};
      zsel = '{zone_idx(chan_zone_1), zone_idx(chan_zone_2), zone_idx(chan_zone_3)};
      mind = '{min_duty_1, min_duty_2, min_duty_3};
      rng  = '{zone_range_code_1, zone_range_code_2, zone_range_code_3};
      mand = '{manual_duty_1, manual_duty_2, manual_duty_3};
   end

   // one ramp per channel fed by its mapped zone and that zone's range
   for (genvar c = 0; c < 3; c++) begin : g_ramp
      fzo_zone_ramp u_ramp (
         .temp            (temp[zsel[c]]),
         .low_limit       (low_q[zsel[c]]),
         .min_duty        (mind[c]),
         .zone_range_code (rng[zsel[c]]),
         .auto_duty       (ramp[c])
      );
   end

   // ==========================================================
   // override detection and channel duty selection
   logic        any_auto;      // at least one channel in automatic mode
   logic        over_abs;      // some zone above its enabled absolute limit
   logic        limits_valid;  // every low limit programmed
   logic        full_d;
   logic        full_q;
   logic [7:0]  duty_d  [3];
   logic [7:0]  duty_q  [3];

   always_comb begin
      any_auto     = 1'b0;
      over_abs     = 1'b0;
      limits_valid = 1'b1;
      for (int z = 0; z < 3; z++) begin
         // every zone counts, mapped to a channel or not
         if (abs_q[z] != `FZO_ABS_DISABLE && temp[z] > abs_q[z]) begin
            over_abs = 1'b1;
         end
         if (low_q[z] == `FZO_LOW_INVALID) begin
            limits_valid = 1'b0;
         end
      end
      for (int c = 0; c < 3; c++) begin
         if (mode[c] == FZO_MODE_AUTO) begin
            any_auto = 1'b1;
         end
      end
      // recomputed every cycle so the override drops as soon as it clears
      full_d = any_auto && over_abs;
      for (int c = 0; c < 3; c++) begin
         unique case (mode[c])
            FZO_MODE_MANUAL:   duty_d[c] = full_d ? `FZO_DUTY_FULL : mand[c];
            // until all low limits are set, run full rather than trust defaults
            FZO_MODE_AUTO:     duty_d[c] = (full_d || !limits_valid) ?
                                           `FZO_DUTY_FULL : ramp[c];
            FZO_MODE_DISABLED: duty_d[c] = `FZO_DUTY_OFF;
            default:           duty_d[c] = `FZO_DUTY_OFF;   // unused code acts disabled
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         full_q <= 1'b0;
         duty_q <= '{default: `FZO_DUTY_OFF};
      end else begin
         full_q <= full_d;
         duty_q <= duty_d;
      end
   end

   assign full_speed = full_q;
   assign duty_1     = duty_q[0];
   assign duty_2     = duty_q[1];
   assign duty_3     = duty_q[2];

   // ==========================================================
   // xor board test tree; serial bus lines are never part of it
   logic        xor_d;
   logic        xor_q;

   always_comb begin
      // drive pins 2 and 3 are released so the board can toggle them
      xor_d = ^{speed_sense_in, fan_drive_in_2, fan_drive_in_3};
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         xor_q <= 1'b0;
      end else begin
         xor_q <= xen_q ? xor_d : 1'b0;
      end
   end

   assign xor_test_out     = xor_q;
   assign fan_drive_oe_n_2 = xen_q;
   assign fan_drive_oe_n_3 = xen_q;

endmodule : fzo_limit_core

// [tb/fzo_limit_core_chk.sv]
// ==========================================================
// port checker of the fan zone limit core
// assumes it is bound into fzo_limit_core and sees its ports only
`timescale 1ns/1ps
`include "fzo_regs.svh"

module fzo_limit_core_chk
   import fzo_pkg::*;
(
   input wire logic       clk,
   input wire logic       rst_n,
   input wire logic [7:0] reg_addr,
   input wire logic       reg_wr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic       config_lock,
   input wire fzo_mode_t  chan_mode_1,
   input wire fzo_mode_t  chan_mode_2,
   input wire fzo_mode_t  chan_mode_3,
   input wire logic [7:0] manual_duty_1,
   input wire logic [7:0] duty_1,
   input wire logic [7:0] duty_2,
   input wire logic       full_speed,
   input wire logic [3:0] speed_sense_in,
   input wire logic       fan_drive_in_2,
   input wire logic       fan_drive_in_3,
   input wire logic       fan_drive_oe_n_2,
   input wire logic       fan_drive_oe_n_3,
   input wire logic       xor_test_out
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   // helper: override is only legal when some channel runs automatic
   logic any_auto;
   assign any_auto = (chan_mode_1 == FZO_MODE_AUTO) || (chan_mode_2 == FZO_MODE_AUTO) ||
                     (chan_mode_3 == FZO_MODE_AUTO);

   // ==========================================================
   // register port
   a_lock_write_drop: assert property (
      config_lock && reg_wr && reg_addr == `FZO_OFS_XOR |=> $stable(fan_drive_oe_n_2))
      else $error("locked write changed test mode");
   a_xen_readback: assert property (
      reg_addr == `FZO_OFS_XOR |=> reg_rdata == {7'h00, $past(fan_drive_oe_n_2)})
      else $error("test register read differs from pin release");

   // ==========================================================
   // full-speed override
   a_override_auto: assert property (
      full_speed |-> $past(any_auto)) else $error("override without automatic channel");
   a_override_duty: assert property (
      full_speed |-> duty_1 == ($past(chan_mode_1[1]) ? 8'h00 : 8'hff))
      else $error("override duty wrong");
   a_disabled_quiet: assert property (
      chan_mode_2[1] |=> duty_2 == 8'h00) else $error("disabled channel drives");
   a_manual_follow: assert property (
      chan_mode_1 == FZO_MODE_MANUAL |=> duty_1 == (full_speed ? 8'hff : $past(manual_duty_1)))
      else $error("manual channel duty wrong");

   // ==========================================================
   // xor board test tree
   a_xor_tree_value: assert property (
      fan_drive_oe_n_2 |=> xor_test_out == ^{$past(speed_sense_in), $past(fan_drive_in_2),
                                              $past(fan_drive_in_3)})
      else $error("xor tree result wrong");
   a_xor_idle_low: assert property (
      !fan_drive_oe_n_2 |=> !xor_test_out) else $error("test output active outside test mode");
   // an unlocked write of the test register must land on both drive pin releases
   a_test_pins_release: assert property (
      reg_wr && !config_lock && reg_addr == `FZO_OFS_XOR |=>
      fan_drive_oe_n_2 == fan_drive_oe_n_3 && {7'h00, fan_drive_oe_n_2} == ($past(reg_wdata) & 8'h01))
      else $error("test enable write not applied to drive pins");

   c_override: cover property (full_speed);
   c_xor_mode: cover property (fan_drive_oe_n_2 && xor_test_out);
   c_locked_wr: cover property (config_lock && reg_wr);
endmodule : fzo_limit_core_chk

bind fzo_limit_core fzo_limit_core_chk u_chk (
   .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
   .reg_rdata(reg_rdata),
   .config_lock(config_lock), .chan_mode_1(chan_mode_1), .chan_mode_2(chan_mode_2),
   .chan_mode_3(chan_mode_3), .manual_duty_1(manual_duty_1), .duty_1(duty_1), .duty_2(duty_2),
   .full_speed(full_speed), .speed_sense_in(speed_sense_in), .fan_drive_in_2(fan_drive_in_2),
   .fan_drive_in_3(fan_drive_in_3), .fan_drive_oe_n_2(fan_drive_oe_n_2),
   .fan_drive_oe_n_3(fan_drive_oe_n_3), .xor_test_out(xor_test_out));

// [tb/fzo_host.sv]
// ==========================================================
// management host model on the byte register port
// assumes the bench owns clock, reset and the lock level
`timescale 1ns/1ps

module fzo_host (
   input  wire logic       clk,
   input  wire logic [7:0] reg_rdata,
   output logic      [7:0] reg_addr,
   output logic            reg_wr,
   output logic      [7:0] reg_wdata
);
   initial begin
      reg_addr  = 8'h00;
      reg_wr    = 1'b0;
      reg_wdata = 8'h00;
   end

   // one byte write; gap idles first so a slow host can be modelled
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input int gap);
      repeat (gap + 1) @(posedge clk);
      reg_addr  <= a;
      reg_wr    <= 1'b1;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr    <= 1'b0;
      reg_wdata <= ~d;  // data no longer valid, so show the inverse
   endtask : wr

   // read: address sampled one edge, data registered behind it
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      repeat (2) @(posedge clk);
      d = reg_rdata;
   endtask : rd
endmodule : fzo_host

// [tb/fan_zone_limit_override_tb.sv]
// ==========================================================
// self-checking bench of the fan zone limit core
// assumes fzo_host drives the register port and the checker is bound
`timescale 1ns/1ps

module fan_zone_limit_override_tb
   import fzo_pkg::*;
;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        config_lock = 1'b0;
   logic [7:0]  rdata, addr, wdata, v;
   logic        wr, full, oe2, oe3, xo;
   logic [7:0]  temp [1:3] = '{8'h00, 8'h00, 8'h00};
   fzo_mode_t   mode [1:3] = '{FZO_MODE_AUTO, FZO_MODE_MANUAL, FZO_MODE_DISABLED};
   logic [1:0]  zsel [1:3] = '{2'h0, 2'h0, 2'h0};   // zone 3 stays unmapped
   logic [7:0]  mind [1:3] = '{8'h00, 8'h10, 8'h10};
   logic [7:0]  man [1:3] = '{8'h20, 8'h40, 8'h60};
   logic [3:0]  rc [1:3] = '{4'h0, 4'h5, 4'hf};
   logic [3:0]  sense = 4'h0;
   logic [1:0]  pads = 2'b00;
   logic [7:0]  duty [1:3];
   logic [63:0] c;
   int          bad_count = 0;
   int          n_tests = 0;
   int          cycles = 0;
   int          span [16] = '{2, 3, 4, 4, 5, 7, 8, 10, 14, 16, 20, 27, 32, 40, 54, 80};
   logic [7:0]  ofs [6] = '{8'h67, 8'h68, 8'h69, 8'h6a, 8'h6b, 8'h6c};
   // mode1, temps 1..3, absolute limits 1..3, expected override
   // last case: unmapped zone 3 parked at 7fh stays quiet just below it
   logic [63:0] cases [7] = '{64'h01_65_00_00_64_64_64_01, 64'h01_64_00_00_64_64_64_00,
                              64'h01_7f_00_00_80_64_64_00, 64'h01_00_00_65_64_64_64_01,
                              64'h01_cf_00_00_ce_64_64_01, 64'h00_65_00_00_64_64_64_00,
                              64'h01_00_00_7e_64_64_7f_00};

   initial forever #5 clk = ~clk;

   fzo_host host (.clk(clk), .reg_rdata(rdata), .reg_addr(addr), .reg_wr(wr), .reg_wdata(wdata));

   fzo_limit_core dut (
      .clk(clk), .rst_n(rst_n), .reg_addr(addr), .reg_wr(wr), .reg_wdata(wdata), .reg_rdata(rdata),
      .config_lock(config_lock), .zone_temp_1(temp[1]), .zone_temp_2(temp[2]), .zone_temp_3(temp[3]),
      .chan_mode_1(mode[1]), .chan_mode_2(mode[2]), .chan_mode_3(mode[3]), .chan_zone_1(zsel[1]),
      .chan_zone_2(zsel[2]), .chan_zone_3(zsel[3]), .min_duty_1(mind[1]), .min_duty_2(mind[2]),
      .min_duty_3(mind[3]), .zone_range_code_1(rc[1]), .zone_range_code_2(rc[2]),
      .zone_range_code_3(rc[3]), .manual_duty_1(man[1]), .manual_duty_2(man[2]),
      .manual_duty_3(man[3]), .duty_1(duty[1]), .duty_2(duty[2]), .duty_3(duty[3]),
      .full_speed(full), .speed_sense_in(sense), .fan_drive_in_2(pads[1]), .fan_drive_in_3(pads[0]),
      .fan_drive_oe_n_2(oe2), .fan_drive_oe_n_3(oe3), .xor_test_out(xo));

   // ==========================================================
   // compare, read and closing tasks
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      n_tests++;
      if (g !== e) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
      host.rd(a, v);
      chk("reg_rdata", e, v);
   endtask : rdchk
   // outputs lag inputs by one edge; three leaves margin
   task automatic settle();
      repeat (3) @(posedge clk);
   endtask : settle
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : conclude

   // hang guard, far above the roughly 300 cycles the run needs
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         bad_count++;
         conclude();
      end
   end

   // ==========================================================
   // main sequence
   initial begin
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 6; i++) rdchk(ofs[i], (i < 3) ? 8'h80 : 8'h64);
      rdchk(8'h6f, 8'h00);
      rdchk(8'h70, 8'h00);  // unmapped offset reads zero
      for (int i = 0; i < 6; i++) begin
         host.wr(ofs[i], 8'(8'h81 + i), i);  // slow host: growing gaps
         rdchk(ofs[i], 8'(8'h81 + i));
      end
      host.wr(8'h6f, 8'hfe, 0);
      rdchk(8'h6f, 8'h00);  // reserved bits read zero
      config_lock <= 1'b1;
      host.wr(8'h6a, 8'h00, 0);
      host.wr(8'h6f, 8'hff, 0);
      rdchk(8'h6a, 8'h84);
      rdchk(8'h6f, 8'h00);
      config_lock <= 1'b0;
      foreach (cases[k]) begin
         c = cases[k];
         mode[1] <= fzo_mode_t'(c[57:56]);
         temp[1] <= c[55:48];
         temp[2] <= c[47:40];
         temp[3] <= c[39:32];
         for (int j = 0; j < 3; j++) host.wr(ofs[3 + j], c[31 - 8 * j -: 8], 0);
         settle();
         chk("full_speed", c[7:0], {7'h00, full});
         chk("duty_2", c[0] ? 8'hff : 8'h40, duty[2]);
         chk("duty_3", 8'h00, duty[3]);
         if (c[0]) chk("duty_1", 8'hff, duty[1]);
      end
      mode[1] <= FZO_MODE_AUTO;
      mind[1] <= 8'h40;
      temp[1] <= 8'hf0;
      host.wr(8'h67, 8'hfe, 0);
      host.wr(8'h68, 8'h32, 0);
      host.wr(8'h69, 8'h80, 0);
      settle();
      chk("duty_1", 8'hff, duty[1]);
      host.wr(8'h69, 8'h32, 0);
      settle();
      chk("duty_1", 8'h40, duty[1]);
      temp[1] <= 8'hfe;
      settle();
      chk("duty_1", 8'h40, duty[1]);
      mind[1] <= 8'h00;
      settle();
      chk("duty_1", 8'h01, duty[1]);
      for (int k = 0; k < 16; k++) begin
         rc[1] <= 4'(k);
         temp[1] <= 8'hff;
         settle();
         chk("duty_1", 8'(255 / span[k]), duty[1]);
         temp[1] <= 8'(8'hfe + span[k]);
         settle();
         chk("duty_1", 8'hff, duty[1]);
      end
      // out-of-range zone select falls back to zone 1, code 11 acts disabled
      temp[1] <= 8'hfe;
      mode[2] <= FZO_MODE_AUTO;
      zsel[2] <= 2'h3;
      mode[3] <= fzo_mode_t'(2'b11);
      settle();
      chk("duty_2", 8'h10, duty[2]);
      chk("duty_3", 8'h00, duty[3]);
      mode[2] <= FZO_MODE_DISABLED;
      settle();
      chk("duty_2", 8'h00, duty[2]);
      host.wr(8'h6f, 8'h01, 0);
      settle();
      chk("oe_n", 8'h03, {6'h00, oe3, oe2});
      for (int k = 0; k < 7; k++) begin
         {sense, pads} <= 6'(1 << k);
         settle();
         chk("xor_test_out", {7'h00, ^6'(1 << k)}, {7'h00, xo});
      end
      host.wr(8'h68, 8'h33, 0);
      rdchk(8'h68, 8'h33);
      sense <= 4'h1;
      host.wr(8'h6f, 8'h00, 0);
      settle();
      chk("xor_off", 8'h00, {6'h00, oe3 | oe2, xo});
      conclude();
   end
endmodule : fan_zone_limit_override_tb
